// ==== verilog/config_word_bank.v ====
// write-once configuration register bank with wishbone slave
`timescale 1ns/1ps
`include "config_bank_consts.vh"

//////////////////////////////////////////////////////////////////////////////
module config_word_bank #(
   parameter FLASH_KBYTES = 64,
   parameter HAS_REGULATOR = 1,
   parameter [2:0] PART_BITS = 3'h5,
   parameter [4:0] REV_BITS = 5'h03
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [25:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output wire ack_o,
   output wire err_o,
   // flash configuration word source
   input wire [39:0] flashWords,
   // consumer controls
   output wire [15:0] watchdogDivide,
   output wire [31:0] sleepWatchdogDivide,
   output wire [5:0] sleepPrescale,
   output wire sleepWatchdogRun,
   output wire sleepBrownoutRun,
   output wire calendarFromSecondary,
   output wire sleepWatchdogFromInternal,
   output wire serialMask7Bit,
   output wire pinMapLock,
   output wire pinMapWriteAllow,
   // flash request checker
   input wire flashReq,
   input wire [15:0] flashAddr,
   output reg flashGo,
   output reg flashBlocked
);

   localparam integer TOP_INT = FLASH_KBYTES - 1;
   localparam [5:0] TOP_PAGE = TOP_INT[5:0];
   localparam integer PRESCALE_INT = `SLEEP_PRESCALE;
   localparam [5:0] PRESCALE = PRESCALE_INT[5:0];
   localparam [5:0] PAGE_MASK = (FLASH_KBYTES <= 16) ? 6'h0F :
      (FLASH_KBYTES <= 32) ? 6'h1F : 6'h3F;
   localparam [7:0] SLEEP_MASK = HAS_REGULATOR ? `MASK_SLEEP_CFG :
      (`MASK_SLEEP_CFG & ~`MASK_SLEEP_ONLY);
   localparam [1:0] ST_LOAD = 2'h0;
   localparam [1:0] ST_RUN = 2'h1;

   reg [1:0] state_reg;
   reg [7:0] wdogScale_reg;
   reg [7:0] sleepCfg_reg;
   reg [7:0] serialLock_reg;
   reg [7:0] protRange_reg;
   reg [7:0] protDis_reg;
   reg [4:0] written_reg;
   reg lock_reg;
   reg lockUsed_reg;
   reg [1:0] unlock_reg;
   reg ack_reg;
   reg [15:0] lastAddr_reg;
   reg [31:0] dat_next;
   reg errFlag_reg;

   wire [23:0] idx = adr_i[25:2];
   wire req = cyc_i & stb_i & ~ack_reg;
   wire wr = req & we_i & sel_i[0];
   wire ready = (state_reg == ST_RUN);
   wire loading = (state_reg == ST_LOAD);
   wire [4:0] take;
   wire reqProtected;

   // word index to config byte slot, 7 when not a config byte
   function [2:0] slotOf;
      input [23:0] a;
      begin
         case (a)
            `IDX_WDOG_SCALE: slotOf = 3'h0;
            `IDX_SLEEP_CFG: slotOf = 3'h1;
            `IDX_SERIAL_LOCK: slotOf = 3'h2;
            `IDX_PROT_RANGE: slotOf = 3'h3;
            `IDX_PROT_DIS: slotOf = 3'h4;
            default: slotOf = 3'h7;
         endcase
      end
   endfunction

   function known;
      input [23:0] a;
      begin
         known = (slotOf(a) != 3'h7) || (a == `IDX_PART_ID) ||
            (a == `IDX_LOAD_CTRL) || (a == `IDX_LOCK_CTRL) ||
            (a == `IDX_FLASH_REQ) || (a == `IDX_STATUS);
      end
   endfunction

   // page protection decision
   function pageProtected;
      input [5:0] page;
      input [7:0] rangeCfg;
      input rangeOff;
      reg [5:0] bound;
      reg inRange;
      begin
         bound = rangeCfg[5:0] & PAGE_MASK;
         inRange = rangeCfg[6] ? (page >= bound) : (page <= bound);
         pageProtected = (~rangeOff & inRange) |
            (~rangeCfg[7] & (page == TOP_PAGE));
      end
   endfunction

   // true for the first write to the given config byte slot
   function firstWrite;
      input integer slot;
      input [23:0] a;
      input [4:0] done;
      begin
         firstWrite = ({29'h0, slotOf(a)} == slot) && !done[slot];
      end
   endfunction

   // watchdog divide code to ratio, 1:1 up to 1:32768
   function [15:0] watchdogRatio;
      input [3:0] code;
      begin
         case (code)
            4'h0: watchdogRatio = 16'h0001;
            4'h1: watchdogRatio = 16'h0002;
            4'h2: watchdogRatio = 16'h0004;
            4'h3: watchdogRatio = 16'h0008;
            4'h4: watchdogRatio = 16'h0010;
            4'h5: watchdogRatio = 16'h0020;
            4'h6: watchdogRatio = 16'h0040;
            4'h7: watchdogRatio = 16'h0080;
            4'h8: watchdogRatio = 16'h0100;
            4'h9: watchdogRatio = 16'h0200;
            4'hA: watchdogRatio = 16'h0400;
            4'hB: watchdogRatio = 16'h0800;
            4'hC: watchdogRatio = 16'h1000;
            4'hD: watchdogRatio = 16'h2000;
            4'hE: watchdogRatio = 16'h4000;
            4'hF: watchdogRatio = 16'h8000;
            default: watchdogRatio = 16'h0001;
         endcase
      end
   endfunction

   // deep-sleep divide code to ratio, four times per step from 1:2
   function [31:0] sleepRatio;
      input [3:0] code;
      begin
         case (code)
            4'h0: sleepRatio = 32'h00000002;
            4'h1: sleepRatio = 32'h00000008;
            4'h2: sleepRatio = 32'h00000020;
            4'h3: sleepRatio = 32'h00000080;
            4'h4: sleepRatio = 32'h00000200;
            4'h5: sleepRatio = 32'h00000800;
            4'h6: sleepRatio = 32'h00002000;
            4'h7: sleepRatio = 32'h00008000;
            4'h8: sleepRatio = 32'h00020000;
            4'h9: sleepRatio = 32'h00080000;
            4'hA: sleepRatio = 32'h00200000;
            4'hB: sleepRatio = 32'h00800000;
            4'hC: sleepRatio = 32'h02000000;
            4'hD: sleepRatio = 32'h08000000;
            4'hE: sleepRatio = 32'h20000000;
            4'hF: sleepRatio = 32'h80000000;
            default: sleepRatio = 32'h00000002;
         endcase
      end
   endfunction

   assign ack_o = ack_reg & ~errFlag_reg;
   assign err_o = ack_reg & errFlag_reg;

   //////////////////////////////////////////////////////////////////////////
   // bus handshake, one answer per request
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
         errFlag_reg <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_reg <= req;
         errFlag_reg <= req & ~known(idx);
         if (req)
            dat_o <= dat_next;
      end
   end

   // load once after reset; later flash edits wait for reset
   always @(posedge clk or posedge rst) begin
      if (rst)
         state_reg <= ST_LOAD;
      else begin
         case (state_reg)
            ST_LOAD: state_reg <= ST_RUN;
            ST_RUN: state_reg <= ST_RUN;
            default: state_reg <= ST_LOAD;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // write-once strobes, one per config byte
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : gen_take
         assign take[g] = wr & ready & firstWrite(g, idx, written_reg);
      end
   endgenerate

   always @(posedge clk or posedge rst) begin
      if (rst)
         written_reg <= 5'h00;
      else
         written_reg <= written_reg | take;
   end

   // watchdog divide byte
   always @(posedge clk or posedge rst) begin
      if (rst)
         wdogScale_reg <= `CFG_RESET;
      else if (loading)
         wdogScale_reg <= flashWords[7:0] & `MASK_WDOG_SCALE;
      else if (take[0])
         wdogScale_reg <= dat_i[7:0] & `MASK_WDOG_SCALE;
   end

   // deep-sleep byte, sleep bits dropped without a regulator
   always @(posedge clk or posedge rst) begin
      if (rst)
         sleepCfg_reg <= `CFG_RESET;
      else if (loading)
         sleepCfg_reg <= flashWords[15:8] & SLEEP_MASK;
      else if (take[1])
         sleepCfg_reg <= dat_i[7:0] & SLEEP_MASK;
   end

   // serial mask and lock policy byte
   always @(posedge clk or posedge rst) begin
      if (rst)
         serialLock_reg <= `CFG_RESET;
      else if (loading)
         serialLock_reg <= flashWords[23:16] & `MASK_SERIAL_LOCK;
      else if (take[2])
         serialLock_reg <= dat_i[7:0] & `MASK_SERIAL_LOCK;
   end

   // protection range byte
   always @(posedge clk or posedge rst) begin
      if (rst)
         protRange_reg <= `CFG_RESET;
      else if (loading)
         protRange_reg <= flashWords[31:24] & `MASK_PROT_RANGE;
      else if (take[3])
         protRange_reg <= dat_i[7:0] & `MASK_PROT_RANGE;
   end

   // range disable byte
   always @(posedge clk or posedge rst) begin
      if (rst)
         protDis_reg <= `CFG_RESET;
      else if (loading)
         protDis_reg <= flashWords[39:32] & `MASK_PROT_DIS;
      else if (take[4])
         protDis_reg <= dat_i[7:0] & `MASK_PROT_DIS;
   end

   //////////////////////////////////////////////////////////////////////////
   // pin map lock with unlock sequence
   wire lockWr = wr & ready & (idx == `IDX_LOCK_CTRL);
   wire unlocked = (unlock_reg == 2'h2);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_reg <= 1'b0;
         lockUsed_reg <= 1'b0;
         unlock_reg <= 2'h0;
      end else if (lockWr) begin
         if (dat_i[7:0] == `UNLOCK_KEY1)
            unlock_reg <= 2'h1;
         else if (dat_i[7:0] == `UNLOCK_KEY2 && unlock_reg == 2'h1)
            unlock_reg <= 2'h2;
         else begin
            unlock_reg <= 2'h0;
            if (unlocked) begin
               if (serialLock_reg[0]) begin
                  if (!lockUsed_reg && dat_i[0]) begin
                     lock_reg <= 1'b1;
                     lockUsed_reg <= 1'b1;
                  end
               end else
                  lock_reg <= dat_i[0];
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // flash request check, byte address to 1024-byte page
   wire [5:0] reqPage = flashAddr[15:10];
   assign reqProtected = pageProtected(reqPage, protRange_reg,
      protDis_reg[0]);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         flashGo <= 1'b0;
         flashBlocked <= 1'b0;
         lastAddr_reg <= 16'h0000;
      end else begin
         flashGo <= 1'b0;
         if (flashReq & ready) begin
            lastAddr_reg <= flashAddr;
            flashGo <= ~reqProtected;
            flashBlocked <= reqProtected;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // read mux
   always @* begin
      dat_next = 32'h00000000;
      case (idx)
         `IDX_WDOG_SCALE: dat_next[7:0] = wdogScale_reg;
         `IDX_SLEEP_CFG: dat_next[7:0] = sleepCfg_reg;
         `IDX_SERIAL_LOCK: dat_next[7:0] = serialLock_reg;
         `IDX_PROT_RANGE: dat_next[7:0] = protRange_reg;
         `IDX_PROT_DIS: dat_next[7:0] = protDis_reg;
         `IDX_PART_ID: dat_next[7:0] = {PART_BITS, REV_BITS};
         `IDX_LOAD_CTRL: dat_next[4:0] = written_reg;
         `IDX_LOCK_CTRL: dat_next[1:0] = {lockUsed_reg, lock_reg};
         `IDX_FLASH_REQ: dat_next[15:0] = lastAddr_reg;
         `IDX_STATUS: dat_next[1:0] = {flashBlocked, ready};
         default: dat_next = 32'h00000000;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // decoded controls
   assign watchdogDivide = watchdogRatio(wdogScale_reg[3:0]);
   assign sleepWatchdogDivide = sleepRatio(sleepCfg_reg[7:4]);
   assign sleepPrescale = PRESCALE;
   assign sleepWatchdogRun = sleepCfg_reg[3];
   assign sleepBrownoutRun = sleepCfg_reg[2];
   assign calendarFromSecondary = sleepCfg_reg[1];
   assign sleepWatchdogFromInternal = sleepCfg_reg[0];
   assign serialMask7Bit = serialLock_reg[3];
   assign pinMapLock = lock_reg;
   assign pinMapWriteAllow = ~lock_reg & unlocked;

endmodule

// ==== inc/config_bank_consts.vh ====
// constants for the nonvolatile configuration word bank
`ifndef CONFIG_BANK_CONSTS_VH
`define CONFIG_BANK_CONSTS_VH
// register byte offsets used as word index (printed offsets are not multiples of four)
`define IDX_WDOG_SCALE 24'h300003
`define IDX_SLEEP_CFG 24'h300004
`define IDX_SERIAL_LOCK 24'h300005
`define IDX_PROT_RANGE 24'h300006
`define IDX_PROT_DIS 24'h300007
`define IDX_PART_ID 24'h3FFFFE
// own registers, word index
`define IDX_LOAD_CTRL 24'h310000
`define IDX_LOCK_CTRL 24'h310001
`define IDX_FLASH_REQ 24'h310002
`define IDX_STATUS 24'h310003
// implemented bit masks of the config bytes
`define MASK_WDOG_SCALE 8'hFF
`define MASK_SLEEP_CFG 8'hFF
`define MASK_SERIAL_LOCK 8'hF9
`define MASK_PROT_RANGE 8'hFF
`define MASK_PROT_DIS 8'hF1
`define CFG_RESET 8'hFF
// deep-sleep bits of the sleep config byte, all but the calendar select
`define MASK_SLEEP_ONLY 8'hFD
// deep-sleep watchdog fixed prescale
`define SLEEP_PRESCALE 32
// flash page size in bytes
`define PAGE_BYTES 1024
// unlock sequence bytes
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'hAA
`endif

// ==== tb/config_word_bank_sva.sv ====
// port assertions for the configuration word bank
`timescale 1ns/1ps
module config_word_bank_sva (
   // clock and reset
   input wire clk,
   input wire rst,
   // bus and flash handshake
   input wire cyc_i,
   input wire stb_i,
   input wire ack_o,
   input wire err_o,
   input wire flashReq,
   input wire flashGo,
   input wire flashBlocked,
   // decoded controls
   input wire [15:0] watchdogDivide,
   input wire [31:0] sleepWatchdogDivide,
   input wire [5:0] sleepPrescale,
   input wire pinMapLock,
   input wire pinMapWriteAllow
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=>
      ack_o || err_o) else $error("request not answered next cycle");
   a_ack_cause: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
      else $error("answer without request");
   a_wdog_ratio: assert property ($onehot(watchdogDivide))
      else $error("watchdog ratio not a power of two");
   a_sleep_ratio: assert property ($onehot(sleepWatchdogDivide) &&
      (sleepWatchdogDivide & 32'h55555555) == 32'h0)
      else $error("sleep ratio not an odd power of two");
   a_prescale_fixed: assert property (sleepPrescale == 6'h20)
      else $error("sleep prescale not 32");
   a_flash_answer: assert property (flashReq |=> flashGo != flashBlocked)
      else $error("flash request without one verdict");
   a_go_cause: assert property (flashGo |-> $past(flashReq))
      else $error("flash go without request");
   a_lock_refuse: assert property (pinMapLock |-> !pinMapWriteAllow)
      else $error("map writable while locked");
   a_cfg_hold: assert property (!cyc_i [*2] ##1
      (!cyc_i && !$past(rst, 3)) |->
      $stable(watchdogDivide) && $stable(sleepWatchdogDivide))
      else $error("config changed without a write");
endmodule
////////////////////////////////////////////////////////////
bind config_word_bank config_word_bank_sva i_sva (.clk, .rst, .cyc_i,
   .stb_i, .ack_o, .err_o, .flashReq, .flashGo, .flashBlocked,
   .watchdogDivide, .sleepWatchdogDivide, .sleepPrescale, .pinMapLock,
   .pinMapWriteAllow);

// ==== tb/nonvolatile_config_word_bank_bench.sv ====
// self-checking bench for the configuration word bank
`timescale 1ns/1ps
`include "config_bank_consts.vh"
module nonvolatile_config_word_bank_bench;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic flashReq = 1'b0, flashPend = 1'b0;
   logic [25:0] adr = '0;
   logic [31:0] datW = '0, seed = 32'h0E64E76A;
   logic [39:0] flashWords = '0;
   logic [15:0] flashAddr = '0;
   logic [63:0] r;
   logic [33:0] busE, busQ[$];
   logic [1:0] flashQ[$];
   logic [7:0] v, c[5];
   logic [7:0] mask[5] = '{`MASK_WDOG_SCALE, `MASK_SLEEP_CFG,
      `MASK_SERIAL_LOCK, `MASK_PROT_RANGE, `MASK_PROT_DIS};
   wire [31:0] datR, swDiv;
   wire [15:0] wdDiv;
   wire [5:0] swPre;
   wire ack, err, swRun, sbRun, calSec, swInt, mask7, lock, mapAllow;
   wire flashGo, flashBlocked;
   int errors = 0, comparisons = 0, cycles = 0;
   // id fields arbitrary
   config_word_bank #(.PART_BITS(3'h2), .REV_BITS(5'h11)) i_dut (.clk(clk),
      .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'hF), .dat_i(datW), .dat_o(datR), .ack_o(ack), .err_o(err),
      .flashWords(flashWords), .watchdogDivide(wdDiv),
      .sleepWatchdogDivide(swDiv), .sleepPrescale(swPre),
      .sleepWatchdogRun(swRun), .sleepBrownoutRun(sbRun),
      .calendarFromSecondary(calSec), .sleepWatchdogFromInternal(swInt),
      .serialMask7Bit(mask7), .pinMapLock(lock), .pinMapWriteAllow(mapAllow),
      .flashReq(flashReq), .flashAddr(flashAddr), .flashGo(flashGo),
      .flashBlocked(flashBlocked));
   always #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(string name, logic [47:0] exp, logic [47:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic summarize();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // entry: data care, err, data
   task automatic wb(logic w, logic [23:0] idx, logic [7:0] d, logic [33:0] e);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      datW <= {24'h0, d};
      busQ.push_back(e);
      do @(negedge clk); while (!(ack || err));
      @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(logic [23:0] idx, logic [7:0] x);
      wb(1'b0, idx, 8'h00, {2'b10, 24'h0, x});
   endtask
   task automatic flash(logic [5:0] p);
      logic prot;
      prot = (p == 6'h3F && !c[3][7]) || (!c[4][0] &&
         (c[3][6] ? p >= c[3][5:0] : p <= c[3][5:0]));
      r = {32'h0, rnd()};
      @(posedge clk);
      flashReq <= 1'b1;
      flashAddr <= {p, r[9:0]};
      flashQ.push_back({!prot, prot});
      @(posedge clk);
      flashReq <= 1'b0;
      flashPend <= 1'b1;
      @(posedge clk);
      flashPend <= 1'b0;
   endtask
   task automatic outs();
      @(negedge clk);
      check("divides", {wdDiv, swDiv},
         {16'h1 << c[0][3:0], 32'h2 << {c[1][7:4], 1'b0}});
      check("levels", {swPre, swRun, sbRun, calSec, swInt, mask7},
         {6'h20, c[1][3:0], c[2][3]});
   endtask
   task automatic lockSeq(logic b, logic was);
      wb(1'b1, `IDX_LOCK_CTRL, 8'h55, 34'h0);
      wb(1'b1, `IDX_LOCK_CTRL, 8'hAA, 34'h0);
      @(negedge clk);
      check("mapAllow", !was, mapAllow);
      wb(1'b1, `IDX_LOCK_CTRL, {7'h0, b}, 34'h0);
      @(negedge clk);
      check("mapShut", 1'b0, mapAllow);
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (ack || err) begin
         busE = busQ.pop_front();
         check("busErr", busE[32], err);
         if (busE[33]) check("busData", busE[31:0], datR);
      end
   end
   always @(negedge clk) begin
      if (flashPend) check("flash", flashQ.pop_front(),
         {flashGo, flashBlocked});
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      for (int it = 0; it < 4; it++) begin
         r = {rnd(), rnd()};
         r[7:4] = 4'hF;
         r[23:20] = 4'hF;
         r[39:36] = 4'hF;
         r[16] = it[0];
         @(posedge clk);
         rst <= 1'b1;
         flashWords <= r[39:0];
         repeat (3) @(posedge clk);
         rst <= 1'b0;
         @(posedge clk);
         flashWords <= ~r[39:0];
         for (int i = 0; i < 5; i++) c[i] = r[8*i +: 8];
         outs();
         rd(`IDX_PART_ID, 8'h51);
         wb(1'b0, 24'h200000, 8'h00, {2'b01, 32'h0});
         for (int i = 0; i < 5; i++) begin
            rd(`IDX_WDOG_SCALE + i, c[i] & mask[i]);
            v = rnd();
            if (i % 2 == 0) v[7:4] = 4'hF;
            if (i == 2) v[0] = it[0];
            wb(1'b1, `IDX_WDOG_SCALE + i, v, 34'h0);
            wb(1'b1, `IDX_WDOG_SCALE + i, ~v, 34'h0);
            c[i] = v;
            rd(`IDX_WDOG_SCALE + i, c[i] & mask[i]);
         end
         outs();
         for (int k = 0; k < 8; k++)
            flash(k < 3 ? 6'(c[3][5:0] + k - 1) : k == 3 ? 6'h3F : 6'(rnd()));
         lockSeq(1'b1, 1'b0);
         check("lockSet", 1'b1, lock);
         lockSeq(1'b0, 1'b1);
         check("lockClear", c[2][0], lock);
      end
      summarize();
   end
endmodule
